/* rcw_pkg.sv */
// Package for the reset cause and timeout guard block.
// Assumes a 10 MHz system clock and an Avalon-MM register slave.
package rcw_pkg;
  // Clock rate
  localparam int unsigned CLK_HZ = 10000000;
  // Register byte addresses (one 32-bit word each)
  localparam logic [3:0] ADDR_CTRL = 4'h0; // reset_source_control_register
  localparam logic [3:0] ADDR_CAUSE = 4'h4; // reset_cause_register
  localparam logic [3:0] ADDR_GUARD = 4'h8; // timeout_guard_register
  // Control register fields
  localparam int unsigned CTRL_UNLOCK = 7;
  localparam int unsigned CTRL_PCONF = 6;
  localparam int unsigned CTRL_BADACC = 5;
  localparam int unsigned CTRL_GUARD = 4;
  // Cause register fields
  localparam int unsigned CAUSE_SLEEP_REQ = 7;
  localparam int unsigned CAUSE_ASLEEP = 6;
  localparam int unsigned CAUSE_BADACC = 5;
  localparam int unsigned CAUSE_GUARD = 4;
  localparam int unsigned CAUSE_PORT = 3;
  // Guard key values
  localparam logic [3:0] KEY_FIRST = 4'hA;
  localparam logic [3:0] KEY_SECOND = 4'h3;
  // Guard counter limit that fires reset
  localparam logic [3:0] GUARD_LIMIT = 4'h8;
  // Timing: guard timeout in ms, power-up hold in ms
  localparam int unsigned GUARD_TIMEOUT_MS = 2000;
  localparam int unsigned POWER_UP_HOLD_MIN_MS = 5;
  localparam int unsigned POWER_UP_HOLD_MAX_MS = 20;
  // Hold chosen at the minimum, in whole cycles with no rounding
  localparam int unsigned POWER_UP_HOLD_CYC =
    (POWER_UP_HOLD_MIN_MS * (CLK_HZ / 1000));
  // Tick period: eight ticks span the timeout, rounded up
  localparam int unsigned GUARD_TICK_CYC =
    (GUARD_TIMEOUT_MS * (CLK_HZ / 1000) + 7) / 8;
endpackage

/* rcw_top.sv */
// Reset cause recording, reset source enables and timeout guard.
// Assumes synchronous power-on and pin inputs, Avalon-MM register access.
//
// Design decisions made here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
module rcw_top #(
  parameter int unsigned HOLD_CYC = rcw_pkg::POWER_UP_HOLD_CYC,
  parameter int unsigned TICK_CYC = rcw_pkg::GUARD_TICK_CYC
) (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic power_on_in,
  input wire logic ext_reset_n_in,
  input wire logic port_comb_in,
  input wire logic bad_access_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic global_reset_out,
  output logic port_setup_reset_out,
  output logic cold_reset_out,
  output logic sleep_out
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  // All registers of the block in one record
  typedef struct packed {
    logic [31:0] hold_cnt;   // Power-up hold countdown
    logic [31:0] tick_cnt;   // Slow tick divider
    logic [3:0] guard_cnt;   // Guard counter
    logic key_armed;         // First key seen on last guard write
    logic unlock;            // Sleep entry unlock
    logic pconf_en;          // Port setup reset enable
    logic badacc_en;         // Bad access reset enable
    logic guard_en;          // Guard reset enable
    logic asleep;            // Sleep state
    logic c_asleep;          // Was asleep marker
    logic c_badacc;          // Cause: bad access
    logic c_guard;           // Cause: guard timeout
    logic c_port;            // Cause: port combination
    logic glob;              // Registered global reset
    logic ack;               // Bus answer phase
    logic [31:0] rdata;      // Read data
  } rcw_state_t;

  rcw_state_t cur_ff;
  rcw_state_t nxt_cur;

  // Cold reset covers power-on, the pin low and the hold period
  logic cold;
  logic hold_busy;
  logic guard_fire;
  logic bad_fire;
  logic port_fire;
  logic bus_req;
  logic wr_take;
  logic rd_take;

  assign hold_busy = (cur_ff.hold_cnt != 32'h0);
  assign cold = sys_rst_in | power_on_in | ~ext_reset_n_in | hold_busy;
  assign guard_fire = cur_ff.guard_en &
    (cur_ff.guard_cnt >= rcw_pkg::GUARD_LIMIT);
  assign bad_fire = bad_access_in & cur_ff.badacc_en;
  assign port_fire = port_comb_in;
  // One wait cycle per access, then answer
  assign bus_req = avs_read_in | avs_write_in;
  // A write lands only at the edge where waitrequest is seen low, so a
  // master that waits for the answer never commits a value twice.
  assign wr_take = avs_write_in & cur_ff.ack;
  assign rd_take = avs_read_in & ~cur_ff.ack;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  // The hold counter is reloaded every cycle while power-on is high or the pin is low.
  // Cause flags sit in the cold domain so warm resets keep them.
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.ack = bus_req & ~cur_ff.ack;
    // Tick divider runs free of any enable; warm and cold resets zero it
    if (cur_ff.tick_cnt >= 32'(TICK_CYC - 1)) begin
      nxt_cur.tick_cnt = 32'h0;
    end else begin
      nxt_cur.tick_cnt = cur_ff.tick_cnt + 32'h1;
    end
    // Register reads
    if (rd_take) begin
      nxt_cur.rdata = 32'h0;
      unique case (avs_address_in)
        rcw_pkg::ADDR_CTRL: begin
          nxt_cur.rdata[rcw_pkg::CTRL_UNLOCK] = cur_ff.unlock;
          nxt_cur.rdata[rcw_pkg::CTRL_PCONF] = cur_ff.pconf_en;
          nxt_cur.rdata[rcw_pkg::CTRL_BADACC] = cur_ff.badacc_en;
          nxt_cur.rdata[rcw_pkg::CTRL_GUARD] = cur_ff.guard_en;
        end
        rcw_pkg::ADDR_CAUSE: begin
          // Sleep request bit reads zero
          nxt_cur.rdata[rcw_pkg::CAUSE_ASLEEP] = cur_ff.c_asleep;
          nxt_cur.rdata[rcw_pkg::CAUSE_BADACC] = cur_ff.c_badacc;
          nxt_cur.rdata[rcw_pkg::CAUSE_GUARD] = cur_ff.c_guard;
          nxt_cur.rdata[rcw_pkg::CAUSE_PORT] = cur_ff.c_port;
        end
        rcw_pkg::ADDR_GUARD: begin
          nxt_cur.rdata[3:0] = cur_ff.guard_cnt;
        end
        default: begin
          nxt_cur.rdata = 32'h0; // Unmapped reads return zero
        end
      endcase
    end
    // Register writes
    if (wr_take) begin
      unique case (avs_address_in)
        rcw_pkg::ADDR_CTRL: begin
          nxt_cur.unlock = avs_writedata_in[rcw_pkg::CTRL_UNLOCK];
          nxt_cur.pconf_en = avs_writedata_in[rcw_pkg::CTRL_PCONF];
          nxt_cur.badacc_en = avs_writedata_in[rcw_pkg::CTRL_BADACC];
          // Only a one is taken: software cannot clear it
          nxt_cur.guard_en = cur_ff.guard_en |
            avs_writedata_in[rcw_pkg::CTRL_GUARD];
        end
        rcw_pkg::ADDR_CAUSE: begin
          // Writing zero clears a flag
          nxt_cur.c_asleep = cur_ff.c_asleep &
            avs_writedata_in[rcw_pkg::CAUSE_ASLEEP];
          nxt_cur.c_badacc = cur_ff.c_badacc &
            avs_writedata_in[rcw_pkg::CAUSE_BADACC];
          nxt_cur.c_guard = cur_ff.c_guard &
            avs_writedata_in[rcw_pkg::CAUSE_GUARD];
          nxt_cur.c_port = cur_ff.c_port &
            avs_writedata_in[rcw_pkg::CAUSE_PORT];
          // Sleep request honoured only when unlocked
          if (avs_writedata_in[rcw_pkg::CAUSE_SLEEP_REQ] &
              cur_ff.unlock) begin
            nxt_cur.asleep = 1'b1;
          end
        end
        rcw_pkg::ADDR_GUARD: begin
          // Key pair must be back to back on this register
          if (cur_ff.key_armed &&
              avs_writedata_in[3:0] == rcw_pkg::KEY_SECOND) begin
            nxt_cur.guard_cnt = 4'h0;
            nxt_cur.key_armed = 1'b0;
          end else begin
            // Any value but the first key disarms the pending clear
            nxt_cur.key_armed =
              (avs_writedata_in[3:0] == rcw_pkg::KEY_FIRST);
          end
        end
        default: begin
          nxt_cur.key_armed = cur_ff.key_armed; // Unmapped writes ignored
        end
      endcase
    end
    // Guard counting on the slow tick, saturating at the limit
    if (cur_ff.tick_cnt == 32'h0 && cur_ff.guard_cnt < rcw_pkg::GUARD_LIMIT
        && !(wr_take && avs_address_in == rcw_pkg::ADDR_GUARD)) begin
      nxt_cur.guard_cnt = cur_ff.guard_cnt + 4'h1;
    end
    // Events set causes; set wins over a software clear
    if (bad_fire) begin
      nxt_cur.c_badacc = 1'b1;
    end
    if (guard_fire) begin
      nxt_cur.c_guard = 1'b1;
    end
    if (port_fire) begin
      nxt_cur.c_port = 1'b1;
      // A port reset ends sleep and marks it
      if (cur_ff.asleep) begin
        nxt_cur.c_asleep = 1'b1;
      end
    end
    // Global reset: cold, the port source, or an enabled bad access or guard source
    nxt_cur.glob = bad_fire | guard_fire | port_fire;
    if (cur_ff.glob) begin
      // Warm reset zeroes guard and leaves sleep; causes kept
      nxt_cur.guard_cnt = 4'h0;
      nxt_cur.key_armed = 1'b0;
      nxt_cur.asleep = 1'b0;
      nxt_cur.tick_cnt = 32'h0;
    end
    // Hold countdown after power-up
    if (hold_busy) begin
      nxt_cur.hold_cnt = cur_ff.hold_cnt - 32'h1;
    end
    // Cold reset clears everything incl. causes
    if (power_on_in | ~ext_reset_n_in) begin
      nxt_cur = '0;
      nxt_cur.hold_cnt = 32'(HOLD_CYC);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  // Synchronous reset also starts the power-up hold
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      cur_ff <= '0;
      cur_ff.hold_cnt <= 32'(HOLD_CYC);
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign avs_waitrequest_out = bus_req & ~cur_ff.ack;
  assign avs_readdata_out = cur_ff.rdata;
  assign cold_reset_out = cold;
  assign global_reset_out = cold | cur_ff.glob;
  assign port_setup_reset_out = cold |
    (cur_ff.glob & cur_ff.pconf_en);
  assign sleep_out = cur_ff.asleep | cold;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence key_pair_s;
    (wr_take && avs_address_in == rcw_pkg::ADDR_GUARD &&
     avs_writedata_in[3:0] == rcw_pkg::KEY_SECOND && cur_ff.key_armed);
  endsequence

  // A warm reset: registered global up and the global reset output up
  sequence warm_s;
    (cur_ff.glob && global_reset_out);
  endsequence

  // A cold source as it is sampled on the pins
  sequence cold_src_s;
    (power_on_in || !ext_reset_n_in);
  endsequence

  chk_guard_clear: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) key_pair_s and (!cur_ff.glob && !cold)
      |=> cur_ff.guard_cnt == 4'h0)
    else $error("guard not cleared by key pair");
  chk_guard_fire: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) cur_ff.guard_en &&
      cur_ff.guard_cnt == rcw_pkg::GUARD_LIMIT
      && !cold |=> global_reset_out && cur_ff.c_guard)
    else $error("guard limit gave no reset");
  // Any guard write other than the first key leaves nothing pending
  chk_guard_abort: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) wr_take &&
      avs_address_in == rcw_pkg::ADDR_GUARD &&
      avs_writedata_in[3:0] != rcw_pkg::KEY_FIRST |=> !cur_ff.key_armed)
    else $error("guard clear left armed");
  // Warm reset zeroes the guard count and ends sleep
  chk_warm_zero: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) warm_s |=> cur_ff.guard_cnt == 4'h0 &&
      !cur_ff.asleep)
    else $error("warm reset kept guard or sleep");
  // Each cold source restarts the full power-up hold
  chk_hold_restart: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) cold_src_s |=>
      cur_ff.hold_cnt == 32'(HOLD_CYC) && cold_reset_out)
    else $error("power-up hold not restarted");
  // While the hold runs, every reset output stays asserted
  chk_hold_cold: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) hold_busy |->
      global_reset_out && port_setup_reset_out && cold_reset_out)
    else $error("reset released during hold");
  // An enabled bad access is recorded as its cause
  chk_badacc_cause: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) bad_fire && ext_reset_n_in && !power_on_in
      |=> cur_ff.c_badacc && cur_ff.glob)
    else $error("bad access cause not recorded");
  // A port reset out of sleep leaves the asleep marker behind
  chk_asleep_mark: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) port_comb_in && cur_ff.asleep &&
      ext_reset_n_in && !power_on_in |=> cur_ff.c_asleep)
    else $error("asleep marker not set");
  // The sleep request bit never reads back as one
  chk_sleep_rd0: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) rd_take &&
      avs_address_in == rcw_pkg::ADDR_CAUSE |=>
      !avs_readdata_out[rcw_pkg::CAUSE_SLEEP_REQ])
    else $error("sleep request read as one");
  chk_guard_sticky: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) cur_ff.guard_en && power_on_in == 1'b0 &&
      ext_reset_n_in |=> cur_ff.guard_en)
    else $error("guard enable dropped");
  chk_sleep_lock: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) !cur_ff.asleep && !cur_ff.unlock |=>
      !cur_ff.asleep)
    else $error("sleep entered while locked");
  chk_cause_cold: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) !ext_reset_n_in |=>
      !cur_ff.c_port && !cur_ff.c_guard && !cur_ff.c_badacc)
    else $error("cold reset left a cause");
  chk_bad_gate: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) bad_access_in && !cur_ff.badacc_en &&
      !guard_fire && !port_fire |=> !cur_ff.glob)
    else $error("bad access reset while disabled");
  chk_port_cause: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) port_comb_in && ext_reset_n_in &&
      !power_on_in |=> cur_ff.c_port ##1 cur_ff.c_port || !ext_reset_n_in
      || power_on_in || $past(wr_take))
    else $error("port cause not recorded");
  chk_pconf_gate: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) port_setup_reset_out |-> global_reset_out)
    else $error("port reset without global reset");

endmodule

/* rcw_top_bench.sv */
// Self-checking bench for the reset cause and timeout guard block.
// Assumes rcw_pkg and rcw_top are compiled first; one 10 MHz clock.
`timescale 1ns/1ps
module rcw_top_bench;
  logic sys_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic power_on_in = 1'b0;
  logic ext_reset_n_in = 1'b1; // Pin idles high
  logic port_comb_in = 1'b0;
  logic bad_access_in = 1'b0;
  logic [3:0] avs_address_in = 4'h0;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic global_reset_out;
  logic port_setup_reset_out;
  logic cold_reset_out;
  logic sleep_out;
  int mismatches = 0;
  int check_count = 0;
  logic [31:0] rd;
  logic ps;
  ////////////////////////////////////////////////////////////////////////
  // Short hold and tick keep the run small; eight ticks are 32 cycles
  rcw_top #(.HOLD_CYC(4), .TICK_CYC(4)) i_rcw_top (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .power_on_in(power_on_in),
    .ext_reset_n_in(ext_reset_n_in),
    .port_comb_in(port_comb_in),
    .bad_access_in(bad_access_in),
    .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .global_reset_out(global_reset_out),
    .port_setup_reset_out(port_setup_reset_out),
    .cold_reset_out(cold_reset_out),
    .sleep_out(sleep_out)
  );
  // 100 ns period
  always #50 sys_clk_in = ~sys_clk_in;
  ////////////////////////////////////////////////////////////////////////
  // Verdict and end of run, the only exit
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Compare one value against its expectation
  task automatic chk(input string name, input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One Avalon cycle; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= ~wr;
    for (int i = 0; i < 20; i++) begin
      @(posedge sys_clk_in);
      if (avs_waitrequest_out === 1'b0) begin
        q = avs_readdata_out; // Taken at the accepting edge only
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
        @(posedge sys_clk_in);
        return;
      end
    end
    mismatches++;
    finish_test();
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  // Bounded wait for global (sel 0) or cold (sel 1) to reach lvl
  task automatic wait_for(input int sel, input logic lvl, input int n,
                          input bit must, output logic seen);
    seen = 1'b0;
    for (int i = 0; i < n && !seen; i++) begin
      @(posedge sys_clk_in);
      ps = port_setup_reset_out;
      seen = ((sel == 0) ? global_reset_out : cold_reset_out) === lvl;
    end
    if (must && !seen) begin
      mismatches++;
      finish_test();
    end
  endtask
  // One-cycle pulse on a source input
  task automatic pulse(input int which);
    if (which == 0) bad_access_in <= 1'b1;
    else port_comb_in <= 1'b1;
    @(posedge sys_clk_in);
    bad_access_in <= 1'b0;
    port_comb_in <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic sc_guard_keys();
    logic s;
    repeat (60) @(posedge sys_clk_in); // Disabled count saturates
    bus(1'b0, rcw_pkg::ADDR_GUARD, 0, rd);
    chk("guard_sat", rd, 32'h8);
    chk("no_reset", global_reset_out, 1'b0);
    wr(rcw_pkg::ADDR_GUARD, 32'hA);
    wr(rcw_pkg::ADDR_GUARD, 32'h5); // Stray value breaks the pair
    wr(rcw_pkg::ADDR_GUARD, 32'h3);
    bus(1'b0, rcw_pkg::ADDR_GUARD, 0, rd);
    chk("guard_abort", rd, 32'h8);
    wr(rcw_pkg::ADDR_GUARD, 32'hA);
    wr(rcw_pkg::ADDR_GUARD, 32'h3);
    bus(1'b0, rcw_pkg::ADDR_GUARD, 0, rd);
    chk("guard_clear", rd < 32'h2, 1'b1);
  endtask
  task automatic sc_bad_access();
    logic s;
    pulse(0);
    wait_for(0, 1'b1, 6, 0, s);
    chk("badacc_off", s, 1'b0);
    wr(rcw_pkg::ADDR_CTRL, 32'h20);
    pulse(0);
    wait_for(0, 1'b1, 6, 1, s);
    chk("pconf_off", ps, 1'b0);
    wait_for(0, 1'b0, 20, 1, s);
    bus(1'b0, rcw_pkg::ADDR_CAUSE, 0, rd);
    chk("cause_badacc", rd, 32'h20);
  endtask
  task automatic sc_sleep_port();
    logic s;
    wr(rcw_pkg::ADDR_CAUSE, 32'hA0); // Locked: request must be dropped
    repeat (2) @(posedge sys_clk_in);
    chk("sleep_locked", sleep_out, 1'b0);
    wr(rcw_pkg::ADDR_CTRL, 32'hE0);
    wr(rcw_pkg::ADDR_CAUSE, 32'hA0);
    chk("sleep_on", sleep_out, 1'b1);
    bus(1'b0, rcw_pkg::ADDR_CAUSE, 0, rd);
    chk("sleep_rd0", rd, 32'h20);
    pulse(1);
    wait_for(0, 1'b1, 6, 1, s);
    chk("pconf_on", ps, 1'b1);
    wait_for(0, 1'b0, 20, 1, s);
    chk("sleep_off", sleep_out, 1'b0);
    bus(1'b0, rcw_pkg::ADDR_CAUSE, 0, rd);
    chk("cause_port", rd, 32'h68);
  endtask
  task automatic sc_guard_fire();
    logic s;
    // Cleared well inside the timeout before enabling
    wr(rcw_pkg::ADDR_GUARD, 32'hA);
    wr(rcw_pkg::ADDR_GUARD, 32'h3);
    wr(rcw_pkg::ADDR_CTRL, 32'hF0);
    wr(rcw_pkg::ADDR_CTRL, 32'h00); // Guard enable must survive
    bus(1'b0, rcw_pkg::ADDR_CTRL, 0, rd);
    chk("ctrl_sticky", rd, 32'h10);
    wait_for(0, 1'b1, 60, 1, s); // Fires after eight ticks
    chk("pconf_off2", ps, 1'b0);
    wait_for(0, 1'b0, 20, 1, s);
    bus(1'b0, rcw_pkg::ADDR_CAUSE, 0, rd);
    chk("cause_guard", rd, 32'h78);
  endtask
  task automatic sc_pin_reset();
    logic s;
    ext_reset_n_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    ext_reset_n_in <= 1'b1;
    wait_for(1, 1'b0, 30, 1, s);
    bus(1'b0, rcw_pkg::ADDR_CAUSE, 0, rd);
    chk("cause_cold", rd, 32'h0);
    bus(1'b0, rcw_pkg::ADDR_CTRL, 0, rd);
    chk("ctrl_cold", rd, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence: reset, register defaults, then each scenario
  initial begin
    logic s;
    repeat (20) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    wait_for(1, 1'b0, 30, 1, s); // Power-up hold must end
    chk("global_idle", global_reset_out, 1'b0);
    bus(1'b0, rcw_pkg::ADDR_CTRL, 0, rd);
    chk("ctrl_rst", rd, 32'h0);
    bus(1'b0, rcw_pkg::ADDR_CAUSE, 0, rd);
    chk("cause_rst", rd, 32'h0);
    sc_guard_keys();
    sc_bad_access();
    sc_sleep_port();
    sc_guard_fire();
    sc_pin_reset();
    finish_test();
  end
endmodule
